/* File: design/cld_decoder.sv */
// instruction decoder and display state of a character display controller
// assumes the host obeys the busy flag and drives the port synchronously
//
// Contract
// - clear fills spaces, zeroes address counter
// - clear forces increment direction
// - home zeroes counter, cancels shift
// - direction bit steps address up/down
// - auto-shift on display write only
// - no shift on reads or glyph
// - display bit enables or blanks
// - cursor bit shows or hides cursor
// - blink bit alternates cursor cell
// - cursor move steps counter; screen not
// - shift all lines, counter kept
// - two-line cursor wraps to line two
// - width bit selects 8 or 4-bit
// - line bit picks one or two
// - tall font limits addresses to 27h
// - extension strap disables tall font
// - table select; code 11 reserved
// - tall position picks rows 1/9
// - counter steps after each RAM access
`timescale 1ns/1ps
`include "cld_defines.svh"

module cld_decoder (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // straps
    input wire logic three_line_strap,
    input wire logic ext_strap,
    // host port, one transfer per strobe
    input wire logic xfer_strobe,
    input wire logic register_select,
    input wire logic read_not_write,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic busy_flag,
    // display state
    output logic [`CLD_AW-1:0] address_counter,
    output logic display_on,
    output logic cursor_on,
    output logic blink_on,
    output logic bus_width_select,
    output logic two_line,
    output logic tall_font_active,
    output logic tall_font_position,
    output logic [1:0] table_select,
    output logic [`CLD_AW-1:0] shift_offset,
    output logic increment,
    output logic auto_shift,
    output logic glyph_sel
);
    import cld_pkg::*;

    logic [7:0] ram [0:`CLD_RAM_DEPTH-1];
    cld_state_t state_reg;
    logic [`CLD_CNT_W-1:0] cnt_reg;
    logic [`CLD_AW-1:0] wipe_reg;
    logic half_reg;
    logic [3:0] hi_nib_reg;
    logic tall_font_enable;
    logic strap_ext_reg;
    logic byte_valid;
    logic [7:0] byte_val;
    logic accept;
    logic is_instr, is_wr, is_rd;
    logic [`CLD_AW-1:0] step_up, step_dn, limit;

    function automatic logic [`CLD_AW-1:0] cld_step(input logic [`CLD_AW-1:0] a,
                                                    input logic up,
                                                    input logic two,
                                                    input logic [`CLD_AW-1:0] lim,
                                                    input logic glyph);
        logic [`CLD_AW-1:0] r;
        r = a;
        if (glyph) begin
            r = up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
        end else if (two) begin
            // wrap line one's end onto line two
            if (up) begin
                if (a == `CLD_LINE1_LAST) r = `CLD_LINE2_FIRST;
                else if (a == `CLD_LINE2_LAST) r = `CLD_ADDR_ZERO;
                else r = a + 7'h01;
            end else begin
                if (a == `CLD_LINE2_FIRST) r = `CLD_LINE1_LAST;
                else if (a == `CLD_ADDR_ZERO) r = `CLD_LINE2_LAST;
                else r = a - 7'h01;
            end
        end else begin
            if (up) r = (a >= lim) ? `CLD_ADDR_ZERO : a + 7'h01;
            else r = (a == `CLD_ADDR_ZERO) ? lim : a - 7'h01;
        end
        return r;
    endfunction

    always_ff @(posedge core_clk) begin
        if (!rstn) strap_ext_reg <= 1'b0;
        else strap_ext_reg <= ext_strap;
    end

    // tall font only with one line
    assign tall_font_active = tall_font_enable & ~two_line & ~strap_ext_reg;
    assign limit = tall_font_active ? `CLD_TALL_LAST : `CLD_ONE_LINE_LAST;
    assign step_up = cld_step(address_counter, 1'b1, two_line, limit, glyph_sel);
    assign step_dn = cld_step(address_counter, 1'b0, two_line, limit, glyph_sel);

    // nibble pairing in 4-bit mode, high nibble first
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            half_reg <= 1'b0;
            hi_nib_reg <= 4'h0;
        end else if (xfer_strobe && !read_not_write && !bus_width_select && !busy_flag) begin
            half_reg <= ~half_reg;
            if (!half_reg) hi_nib_reg <= data_in[7:4];
        end else if (bus_width_select) begin
            half_reg <= 1'b0;
        end
    end

    always_comb begin
        byte_val = data_in;
        byte_valid = xfer_strobe & ~read_not_write;
        if (!bus_width_select) begin
            byte_val = {hi_nib_reg, data_in[7:4]};
            byte_valid = byte_valid & half_reg;
        end
    end

    assign accept = (state_reg == CLD_IDLE) & byte_valid;
    assign is_instr = accept & ~register_select;
    assign is_wr = accept & register_select;
    assign is_rd = (state_reg == CLD_IDLE) & xfer_strobe & read_not_write & register_select;
    assign busy_flag = (state_reg != CLD_IDLE);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            address_counter <= `CLD_ADDR_ZERO;
            glyph_sel <= 1'b0;
            increment <= 1'b1;
            auto_shift <= 1'b0;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on <= 1'b0;
            bus_width_select <= 1'b1;
            two_line <= 1'b0;
            tall_font_enable <= 1'b0;
            table_select <= `CLD_TBL_NORMAL;
            tall_font_position <= 1'b0;
            shift_offset <= `CLD_ADDR_ZERO;
        end else if (is_instr) begin
            if (byte_val[7]) begin
                address_counter <= byte_val[6:0];
                glyph_sel <= 1'b0;
            end else if (byte_val[6]) begin
                // extension table 1 slot is the icon address, not handled here
                if (table_select == `CLD_TBL_NORMAL) begin
                    address_counter <= {1'b0, byte_val[5:0]};
                    glyph_sel <= 1'b1;
                end
            end else if (byte_val[5]) begin
                bus_width_select <= byte_val[4];
                two_line <= byte_val[3];
                tall_font_enable <= byte_val[2];
                table_select <= byte_val[1:0];
            end else if (byte_val[4]) begin
                if (table_select == `CLD_TBL_NORMAL) begin
                    if (byte_val[3]) begin
                        // screen shift keeps counter
                        // left counts up, the same sense as an auto-shift on increment
                        shift_offset <= byte_val[2] ? shift_offset - 7'h01
                                                    : shift_offset + 7'h01;
                    end else begin
                        address_counter <= byte_val[2] ? step_up : step_dn;
                    end
                end else if (table_select == `CLD_TBL_EXT2) begin
                    tall_font_position <= byte_val[3];
                end
            end else if (byte_val[3]) begin
                display_on <= byte_val[2];
                cursor_on <= byte_val[1];
                blink_on <= byte_val[0];
            end else if (byte_val[2]) begin
                increment <= byte_val[1];
                auto_shift <= byte_val[0];
            end else if (byte_val[1]) begin
                address_counter <= `CLD_ADDR_ZERO;
                shift_offset <= `CLD_ADDR_ZERO;
                glyph_sel <= 1'b0;
            end else if (byte_val[0]) begin
                address_counter <= `CLD_ADDR_ZERO;
                shift_offset <= `CLD_ADDR_ZERO;
                increment <= 1'b1;
                glyph_sel <= 1'b0;
            end
        end else if (is_wr || is_rd) begin
            address_counter <= increment ? step_up : step_dn;
            if (is_wr && auto_shift && !glyph_sel) begin
                shift_offset <= increment ? shift_offset + 7'h01 : shift_offset - 7'h01;
            end
        end
    end

    // busy timing; clear runs a wipe of the whole memory first
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= CLD_IDLE;
            cnt_reg <= '0;
            wipe_reg <= `CLD_ADDR_ZERO;
        end else begin
            case (state_reg)
                CLD_IDLE: begin
                    if (is_instr && byte_val[7:1] == 7'h00 && byte_val[0]) begin
                        state_reg <= CLD_WIPE;
                        wipe_reg <= `CLD_ADDR_ZERO;
                        cnt_reg <= `CLD_CNT_W'(`CLD_LONG_CYC);
                    end else if (is_instr && byte_val[7:1] == 7'h01) begin
                        state_reg <= CLD_WAIT;
                        cnt_reg <= `CLD_CNT_W'(`CLD_LONG_CYC);
                    end else if (accept || is_rd) begin
                        state_reg <= CLD_WAIT;
                        cnt_reg <= `CLD_CNT_W'(`CLD_SHORT_CYC);
                    end
                end
                CLD_WIPE: begin
                    cnt_reg <= cnt_reg - `CLD_CNT_W'(1);
                    wipe_reg <= wipe_reg + 7'h01;
                    if (wipe_reg == `CLD_WIPE_LAST) state_reg <= CLD_WAIT;
                end
                CLD_WAIT: begin
                    cnt_reg <= cnt_reg - `CLD_CNT_W'(1);
                    if (cnt_reg <= `CLD_CNT_W'(1)) state_reg <= CLD_IDLE;
                end
                default: state_reg <= CLD_IDLE;
            endcase
        end
    end

    // display memory; glyph memory accesses are outside this block
    always_ff @(posedge core_clk) begin
        if (state_reg == CLD_WIPE) ram[wipe_reg] <= `CLD_SPACE_CODE;
        else if (is_wr && !glyph_sel) ram[address_counter] <= byte_val;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) data_out <= 8'h00;
        else if (is_rd) data_out <= ram[address_counter];
        else if (xfer_strobe && read_not_write) data_out <= {busy_flag, address_counter};
    end

    a_clear_incr: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val == 8'h01 |=> increment && address_counter == 7'h00)
        else $error("clear did not force increment");
    a_home_shift: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:1] == 7'h01 |=> shift_offset == 7'h00)
        else $error("home left shift");
    a_busy_block: assert property (@(posedge core_clk) disable iff (!rstn)
        busy_flag |-> !accept)
        else $error("accepted while busy");
    a_accept_busy: assert property (@(posedge core_clk) disable iff (!rstn)
        accept |=> busy_flag)
        else $error("no busy after accept");
    a_no_rd_shift: assert property (@(posedge core_clk) disable iff (!rstn)
        is_rd |=> $stable(shift_offset))
        else $error("shift on read");
    a_screen_ac: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:3] == 5'b00011 && table_select == 2'b00
        |=> $stable(address_counter))
        else $error("counter moved on screen shift");
    a_wrap_line: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr && two_line && increment && !glyph_sel && address_counter == 7'h27
        |=> address_counter == 7'h40)
        else $error("no wrap to second line");
    a_strap_tall: assert property (@(posedge core_clk) disable iff (!rstn)
        strap_ext_reg |-> !tall_font_active)
        else $error("tall font with strap high");
    a_wr_step: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr && !two_line && !increment && !glyph_sel && address_counter == 7'h05
        |=> address_counter == 7'h04)
        else $error("counter did not decrement");
    a_display_ctl: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:3] == 5'b00001 |=> display_on == $past(byte_val[2])
        && cursor_on == $past(byte_val[1]) && blink_on == $past(byte_val[0]))
        else $error("display control bits not taken");
    a_entry_mode: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:2] == 6'b000001
        |=> increment == $past(byte_val[1]) && auto_shift == $past(byte_val[0]))
        else $error("entry mode bits not taken");
    a_func_set: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:5] == 3'b001 |=> bus_width_select == $past(byte_val[4])
        && two_line == $past(byte_val[3]) && table_select == $past(byte_val[1:0]))
        else $error("function set fields not taken");
    a_display_ram_set: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7] |=> address_counter == $past(byte_val[6:0]) && !glyph_sel)
        else $error("display address not loaded");
    a_clear_wipe: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val == 8'h01 |=> state_reg == CLD_WIPE)
        else $error("clear did not start wipe");
    a_glyph_shift: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr && glyph_sel |=> $stable(shift_offset))
        else $error("shift on glyph write");
    a_shift_off: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr && !auto_shift |=> $stable(shift_offset))
        else $error("shift with auto-shift off");
    // tall font wraps at its limit
    a_tall_limit: assert property (@(posedge core_clk) disable iff (!rstn)
        is_wr && tall_font_active && increment && !glyph_sel
        && address_counter == `CLD_TALL_LAST |=> address_counter == `CLD_ADDR_ZERO)
        else $error("tall font address past limit");
    a_screen_shift: assert property (@(posedge core_clk) disable iff (!rstn)
        is_instr && byte_val[7:3] == 5'b00011 && table_select == `CLD_TBL_NORMAL
        |=> shift_offset != $past(shift_offset))
        else $error("screen shift did not move display");
    a_busy_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        busy_flag && xfer_strobe |=> $stable(address_counter) && $stable(display_on))
        else $error("state changed by strobe while busy");
    // strap high one cycle blocks tall font
    a_ext_tall: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(ext_strap) |-> !tall_font_active)
        else $error("tall font with strap high");
    // first nibble alone is no byte
    a_nibble_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        xfer_strobe && !read_not_write && !bus_width_select && !half_reg |-> !accept)
        else $error("byte taken from one nibble");
endmodule

/* File: design/cld_defines.svh */
// constants for the character display instruction decoder
// assumes a 250 MHz core clock; execution times are counted in core cycles
`ifndef CLD_DEFINES_SVH
`define CLD_DEFINES_SVH

`define CLD_AW 7
`define CLD_SPACE_CODE 8'h20
`define CLD_ADDR_ZERO 7'h00
`define CLD_TALL_LAST 7'h27
`define CLD_LINE1_LAST 7'h27
`define CLD_LINE2_FIRST 7'h40
`define CLD_LINE2_LAST 7'h67
`define CLD_ONE_LINE_LAST 7'h4f
`define CLD_RAM_DEPTH 128
`define CLD_WIPE_LAST 7'h7f
`define CLD_CLK_MHZ 250
// execution times in ns
`define CLD_T_LONG_NS 590000
`define CLD_T_SHORT_NS 14300
`define CLD_LONG_CYC ((`CLD_T_LONG_NS * `CLD_CLK_MHZ + 999) / 1000)
`define CLD_SHORT_CYC ((`CLD_T_SHORT_NS * `CLD_CLK_MHZ + 999) / 1000)
`define CLD_CNT_W 18
// table codes
`define CLD_TBL_NORMAL 2'b00
`define CLD_TBL_EXT1 2'b01
`define CLD_TBL_EXT2 2'b10
`define CLD_TBL_TEST 2'b11

`endif

/* File: design/cld_pkg.sv */
// types shared by the instruction decoder
// assumes cld_defines.svh holds the numeric constants
package cld_pkg;
    typedef enum logic [1:0] {
        CLD_IDLE,
        CLD_WIPE,
        CLD_WAIT
    } cld_state_t;
endpackage

/* File: verif/cld_host.sv */
// host model driving the instruction port of the decoder
// assumes busy_flag from cld_decoder on the same clock
`timescale 1ns/1ps
module cld_host (
    // clock
    input wire logic core_clk,
    // decoder port
    input wire logic busy_flag,
    output logic xfer_strobe,
    output logic register_select,
    output logic read_not_write,
    output logic [7:0] data_in
);
    logic four_bit = 1'b0;
    initial xfer_strobe = 1'b0;
    initial register_select = 1'b0;
    initial read_not_write = 1'b0;
    initial data_in = 8'h00;
    // one strobe; released data lines flip so stale values never match
    task automatic pulse(input logic rs, input logic rnw, input logic [7:0] d);
        @(posedge core_clk);
        xfer_strobe <= 1'b1;
        register_select <= rs;
        read_not_write <= rnw;
        data_in <= d;
        @(posedge core_clk);
        xfer_strobe <= 1'b0;
        data_in <= ~d;
    endtask
    task automatic idle();
        int n;
        n = 0;
        @(posedge core_clk);
        while (busy_flag !== 1'b0 && n < 200000) begin
            n++;
            @(posedge core_clk);
        end
    endtask
    task automatic send(input logic rs, input logic rnw, input logic [7:0] d);
        idle();
        if (four_bit && !rnw) begin
            pulse(rs, rnw, {d[7:4], 4'h0});
            idle();
            pulse(rs, rnw, {d[3:0], 4'h0});
        end else begin
            pulse(rs, rnw, d);
        end
        if (!rs && !rnw && d[7:5] == 3'b001) begin
            four_bit = !d[4];
        end
        idle();
    endtask
endmodule

/* File: verif/cld_decoder_tb.sv */
// self-checking bench for the instruction decoder
// assumes cld_host keeps the host side of the port
`timescale 1ns/1ps
`include "cld_defines.svh"
module cld_decoder_tb;
    logic core_clk, rstn, three_line_strap, ext_strap;
    logic xfer_strobe, register_select, read_not_write, busy_flag;
    logic [7:0] data_in, data_out, r;
    logic [`CLD_AW-1:0] address_counter, shift_offset, ea, es;
    logic display_on, cursor_on, blink_on, bus_width_select, two_line;
    logic tall_font_active, tall_font_position, increment, auto_shift, glyph_sel;
    logic [1:0] table_select;
    int seed, miscompares, samples_checked, n;
    cld_decoder dut (.core_clk, .rstn, .three_line_strap, .ext_strap, .xfer_strobe,
        .register_select, .read_not_write, .data_in, .data_out, .busy_flag,
        .address_counter, .display_on, .cursor_on, .blink_on, .bus_width_select,
        .two_line, .tall_font_active, .tall_font_position, .table_select,
        .shift_offset, .increment, .auto_shift, .glyph_sel);
    cld_host host (.core_clk, .busy_flag, .xfer_strobe, .register_select,
        .read_not_write, .data_in);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [`CLD_AW-1:0] nxt(input logic [`CLD_AW-1:0] a, input logic up);
        return up ? a + 7'h01 : a - 7'h01;
    endfunction
    task automatic ins(input logic [7:0] d);
        host.send(1'b0, 1'b0, d);
    endtask
    task automatic wr(input logic [7:0] d);
        host.send(1'b1, 1'b0, d);
    endtask
    task automatic rd();
        host.send(1'b1, 1'b1, 8'h00);
    endtask
    task automatic pos();
        chk(16'(address_counter), 16'(ea));
        chk(16'(shift_offset), 16'(es));
    endtask
    // clear and home are long, so the limit covers both plus the short ones
    initial begin
        #3000000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        seed = 11558;
        miscompares = 0;
        samples_checked = 0;
        rstn = 1'b0;
        // strap kept low, so the host is free to pick one line
        three_line_strap = 1'b0;
        ext_strap = 1'b0;
        ea = '0;
        es = '0;
        repeat (10) @(posedge core_clk);
        chk(16'({display_on, bus_width_select, increment, busy_flag}), 16'h0006);
        rstn <= 1'b1;
        @(posedge core_clk);
        host.pulse(1'b0, 1'b0, 8'h0c);
        n = 0;
        @(posedge core_clk);
        while (busy_flag === 1'b1 && n < 9000) begin
            n++;
            @(posedge core_clk);
        end
        chk(16'(n), 16'd3575);
        chk(16'({display_on, cursor_on, blink_on}), 16'h0004);
        // second strobe lands while busy and must be dropped
        repeat (4) begin
            r = 8'($random(seed));
            host.pulse(1'b0, 1'b0, {5'h01, r[2:0]});
            host.pulse(1'b0, 1'b0, {5'h01, ~r[2:0]});
            host.idle();
            chk(16'({display_on, cursor_on, blink_on}), 16'(r[2:0]));
        end
        for (int i = 0; i < 4; i++) begin
            ins(8'h04 | 8'(i));
            chk(16'({increment, auto_shift}), 16'(i));
            r = 8'($random(seed));
            ea = {2'b01, r[4:0]};
            ins({1'b1, ea});
            wr(r);
            ea = nxt(ea, i[1]);
            if (i[0]) es = nxt(es, i[1]);
            pos();
            rd();
            ea = nxt(ea, i[1]);
            pos();
        end
        for (int i = 0; i < 4; i++) begin
            ins(8'h10 | 8'(i << 2));
            if (i[1]) es = nxt(es, !i[0]);
            else ea = nxt(ea, i[0]);
            pos();
        end
        ins(8'h38);
        chk(16'(two_line), 16'h0001);
        ins(8'ha7);
        ins(8'h14);
        ea = 7'h40;
        pos();
        for (int t = 0; t < 3; t++) begin
            ins(8'h34 | 8'(t));
            chk(16'({table_select, two_line, tall_font_active}), 16'({t[1:0], 2'b01}));
        end
        ins(8'h18);
        chk(16'(tall_font_position), 16'h0001);
        ext_strap <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(16'(tall_font_active), 16'h0000);
        ext_strap <= 1'b0;
        ins(8'h10);
        chk(16'(tall_font_position), 16'h0000);
        ins(8'h30);
        ins(8'h06);
        ins(8'h45);
        wr(8'h1f);
        ea = 7'h06;
        chk(16'(glyph_sel), 16'h0001);
        pos();
        host.send(1'b0, 1'b1, 8'h00);
        chk(16'(data_out), 16'({1'b0, ea}));
        ins(8'h80);
        wr(8'h5a);
        ins(8'h02);
        ea = '0;
        es = '0;
        pos();
        rd();
        chk(16'(data_out), 16'h005a);
        ins(8'h04);
        ins(8'h01);
        ea = '0;
        chk(16'(increment), 16'h0001);
        pos();
        rd();
        chk(16'(data_out), 16'h0020);
        ins(8'h28);
        chk(16'(bus_width_select), 16'h0000);
        ins(8'h0b);
        chk(16'({display_on, cursor_on, blink_on}), 16'h0003);
        ins(8'h38);
        chk(16'(bus_width_select), 16'h0001);
        report_and_stop();
    end
endmodule
